/* File: hdl/itf_defines.svh */
/*
 constants of the temperature, fifo and accelerometer register bank.
 assumes a 100 MHz aclk; byte address of a register is four times its index.
*/
`ifndef ITF_DEFINES_SVH
`define ITF_DEFINES_SVH
`define ITF_ADDR_W 12
`define ITF_IDX_ERR 8'h02
`define ITF_IDX_PMU 8'h03
`define ITF_IDX_ACC_X 8'h12
`define ITF_IDX_ACC_Y 8'h14
`define ITF_IDX_ACC_Z 8'h16
`define ITF_IDX_STATUS 8'h1B
`define ITF_IDX_TEMP 8'h20
`define ITF_IDX_LEVEL 8'h22
`define ITF_IDX_PORT 8'h24
`define ITF_IDX_ACCEL_RATE_FILTER_CONFIG 8'h40
`define ITF_IDX_ACC_RANGE 8'h41
`define ITF_IDX_FIFO_CFG 8'h47
`define ITF_IDX_CMD 8'h7E
`define ITF_CONF_US_BIT 7
`define ITF_STAT_DRDY_BIT 7
`define ITF_STAT_TVALID_BIT 0
`define ITF_CFG_HDR_BIT 4
`define ITF_PMU_ACC_LSB 4
`define ITF_PMU_GYR_LSB 2
`define ITF_ERR_LSB 1
`define ITF_ACCEL_RATE_FILTER_CONFIG_RST 8'h28
`define ITF_ACC_RANGE_RST 4'h3
`define ITF_FIFO_HDR_RST 1'b1
`define ITF_TEMP_INVALID 16'h8000
`define ITF_FIFO_EMPTY_BYTE 8'h80
`define ITF_ERR_ACCEL_RATE_FILTER_CONFIG 4'h6
`define ITF_CMD_ACC_SUSPEND 8'h10
`define ITF_CMD_ACC_NORMAL 8'h11
`define ITF_CMD_ACC_LOW_POWER 8'h12
`define ITF_CMD_FIFO_FLUSH 8'hB0
`define ITF_ODR_MAX 4'hC
`define ITF_ODR_MIN_FILT 4'h5
`define ITF_BWP_MAX_FILT 3'h2
`define ITF_CLK_HZ 100_000_000
`define ITF_TEMP_FAST_MS 10
`define ITF_TEMP_SLOW_MS 1280
`define ITF_TEMP_FAST_CYC (`ITF_TEMP_FAST_MS * (`ITF_CLK_HZ / 1000))
`define ITF_TEMP_SLOW_CYC (`ITF_TEMP_SLOW_MS * (`ITF_CLK_HZ / 1000))
`define ITF_ODR_BASE_HZ 100
`define ITF_ODR_SLOW_CYC ((`ITF_CLK_HZ / `ITF_ODR_BASE_HZ) * 256)
`define ITF_FRAME_BYTES 7
`define ITF_FIFO_DEPTH 1024
`define ITF_SKIP_BYTES 2
`endif

/* File: hdl/itf_pkg.sv */
/*
 types shared by the register bank and its fifo and temperature parts.
 assumes itf_defines.svh is on the include path.
*/
`include "itf_defines.svh"
package itf_pkg;
   typedef enum logic [1:0] {ITF_PMU_SUSPEND, ITF_PMU_NORMAL, ITF_PMU_LOW_POWER, ITF_PMU_FAST_UP} itf_pmu_t;
   typedef enum logic [1:0] {ITF_RANGE_2G, ITF_RANGE_4G, ITF_RANGE_8G, ITF_RANGE_16G} itf_range_t;
   typedef struct packed
   {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } itf_acc_sample_t;
   typedef struct packed
   {
      logic [7:0]      header;
      itf_acc_sample_t payload;
   } itf_frame_t;
endpackage

/* File: hdl/itf_temp.sv */
/*
 die temperature word with its update timer.
 assumes sample comes from same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
module itf_temp
   import itf_pkg::*;
#(
   parameter int unsigned FAST_CYC = `ITF_TEMP_FAST_CYC,
   parameter int unsigned SLOW_CYC = `ITF_TEMP_SLOW_CYC
)
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // power state and sensor
   input  wire logic        all_suspend,
   input  wire itf_pmu_t    gyr_pmu,
   input  wire logic [15:0] sample,
   // readout
   output logic [15:0]      word_q,
   output logic             valid
);
   logic [31:0] cnt_q;
   logic [31:0] period;
   logic        tick;
   assign period = (gyr_pmu == ITF_PMU_NORMAL) ? FAST_CYC : SLOW_CYC;
   assign tick = (cnt_q >= period - 32'd1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn || all_suspend)
         cnt_q <= 32'd0;
      else if (tick)
         cnt_q <= 32'd0;
      else
         cnt_q <= cnt_q + 32'd1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn || all_suspend)
         word_q <= `ITF_TEMP_INVALID;
      else if (tick)
         word_q <= sample;
   end
   assign valid = (gyr_pmu == ITF_PMU_NORMAL) && (word_q != `ITF_TEMP_INVALID);
endmodule
`default_nettype wire

/* File: hdl/itf_fifo.sv */
/*
 frame fifo with byte read port, whole-frame fill counter and partial-frame rewind.
 assumes frames arrive whole in one cycle and pop/abort are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module itf_fifo
   import itf_pkg::*;
#(
   parameter int unsigned DEPTH = `ITF_FIFO_DEPTH,
   parameter int unsigned FB    = `ITF_FRAME_BYTES
)
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // control
   input  wire logic       flush,
   input  wire logic       hdr_mode,
   // frame input
   input  wire logic       wr_valid,
   input  wire itf_frame_t wr_frame,
   // byte read port
   input  wire logic       pop,
   input  wire logic       abort,
   output logic [7:0]      rd_byte,
   output logic [15:0]     level
);
   localparam int PW = $clog2(DEPTH);
   logic [7:0]  mem [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [2:0]    off_q;
   logic [PW:0]   cnt_q;
   logic          skip_q;
   logic [2:0]    start;
   logic          can_wr;
   logic          done;
   logic [FB*8-1:0] flat;
   assign flat = wr_frame;
   assign start = hdr_mode ? 3'd0 : 3'd1;
   assign can_wr = wr_valid && ((PW+1)'(DEPTH) - cnt_q >= (PW+1)'(FB));
   assign done = pop && (cnt_q != '0) && (off_q == 3'(FB - 1));
   assign rd_byte = (cnt_q == '0) ? `ITF_FIFO_EMPTY_BYTE : mem[rd_ptr_q + PW'(off_q)];
   assign level = 16'(cnt_q) + (skip_q ? 16'(`ITF_SKIP_BYTES) : 16'd0);
   always_ff @(posedge aclk)
   begin
      if (can_wr)
         for (int i = 0; i < FB; i++)
            mem[wr_ptr_q + PW'(i)] <= flat[(FB-1-i)*8 +: 8];
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn || flush)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
         skip_q   <= 1'b0;
         off_q    <= start;
      end
      else
      begin
         if (can_wr)
            wr_ptr_q <= wr_ptr_q + PW'(FB);
         if (done)
            rd_ptr_q <= rd_ptr_q + PW'(FB);
         cnt_q <= cnt_q + (can_wr ? (PW+1)'(FB) : '0) - (done ? (PW+1)'(FB) : '0);
         if (wr_valid && !can_wr)
            skip_q <= 1'b1;
         else if (done && cnt_q == (PW+1)'(FB) && !can_wr)
            skip_q <= 1'b0;
         if (done || abort)
            off_q <= start;
         else if (pop && cnt_q != '0)
            off_q <= off_q + 3'd1;
         else if (off_q < start)
            off_q <= start;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/itf_regs.sv */
/*
 temperature, fifo and accelerometer register bank behind an axi4-lite slave.
 assumes sensor and fifo inputs come from logic on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module itf_regs
   import itf_pkg::*;
#(
   parameter int unsigned ADDR_W        = `ITF_ADDR_W,
   parameter int unsigned TEMP_FAST_CYC = `ITF_TEMP_FAST_CYC,
   parameter int unsigned TEMP_SLOW_CYC = `ITF_TEMP_SLOW_CYC,
   parameter int unsigned ODR_SLOW_CYC  = `ITF_ODR_SLOW_CYC,
   parameter int unsigned FIFO_DEPTH    = `ITF_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // sensor side
   input  wire logic              acc_sample_valid,
   input  wire itf_acc_sample_t   acc_sample,
   input  wire itf_pmu_t          gyr_pmu,
   input  wire logic              mag_suspend,
   input  wire logic [15:0]       temp_sample,
   // fifo frame source
   input  wire logic              fifo_wr_valid,
   input  wire itf_frame_t        fifo_wr_frame,
   // accelerometer control
   output itf_pmu_t               acc_pmu_q,
   output itf_range_t             acc_range_sel_q,
   output logic                   acc_undersample_en,
   output logic [2:0]             acc_filter_coeff,
   output logic                   acc_odr_tick_q,
   output logic                   accel_rate_filter_config_error
);
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      if (a[ADDR_W-1:10] != '0 || a[1:0] != 2'b00)
         return 1'b0;
      return i == `ITF_IDX_ERR || i == `ITF_IDX_PMU || i == `ITF_IDX_ACC_X
         || i == `ITF_IDX_ACC_Y || i == `ITF_IDX_ACC_Z || i == `ITF_IDX_STATUS
         || i == `ITF_IDX_TEMP || i == `ITF_IDX_LEVEL || i == `ITF_IDX_PORT
         || i == `ITF_IDX_ACCEL_RATE_FILTER_CONFIG || i == `ITF_IDX_ACC_RANGE
         || i == `ITF_IDX_FIFO_CFG || i == `ITF_IDX_CMD;
   endfunction

   function automatic logic conf_legal(input logic [7:0] c);
      logic [3:0] odr;
      logic [2:0] bwp;
      odr = c[3:0];
      bwp = c[6:4];
      if (odr == 4'h0 || odr > `ITF_ODR_MAX)
         return 1'b0;
      if (!c[`ITF_CONF_US_BIT])
         return bwp <= `ITF_BWP_MAX_FILT && odr >= `ITF_ODR_MIN_FILT;
      return 1'b1;
   endfunction

   function automatic itf_range_t range_decode(input logic [3:0] r);
      unique case (r)
         4'h3: return ITF_RANGE_2G;
         4'h5: return ITF_RANGE_4G;
         4'h8: return ITF_RANGE_8G;
         4'hC: return ITF_RANGE_16G;
         default: return ITF_RANGE_2G;
      endcase
   endfunction

   logic [7:0]      accel_rate_filter_config_q;
   logic [3:0]      acc_range_q;
   logic            fifo_hdr_q;
   itf_acc_sample_t acc_data_q;
   logic            drdy_q;
   logic            bvalid_q;
   logic [1:0]      bresp_q;
   logic            rvalid_q;
   logic [1:0]      rresp_q;
   logic [31:0]     rdata_q;
   logic [31:0]     odr_cnt_q;
   logic [31:0]     odr_period;
   logic            wr_fire;
   logic            rd_fire;
   logic [7:0]      wr_idx;
   logic [7:0]      rd_idx;
   logic            wr_ok;
   logic            rd_ok;
   logic            cmd_wr;
   logic [7:0]      cmd;
   logic            flush;
   logic            all_suspend;
   logic            legal;
   logic [15:0]     temp_word;
   logic            temp_valid;
   logic [7:0]      fifo_byte;
   logic [15:0]     fifo_level;
   logic            fifo_pop;
   logic            fifo_abort;
   logic            acc_rd;

   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign rd_fire = s_axi_arvalid && !rvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   assign wr_idx = s_axi_awaddr[9:2];
   assign rd_idx = s_axi_araddr[9:2];
   assign wr_ok = wr_fire && idx_mapped(s_axi_awaddr) && s_axi_wstrb[0];
   assign rd_ok = idx_mapped(s_axi_araddr);
   assign cmd_wr = wr_ok && wr_idx == `ITF_IDX_CMD;
   assign cmd = s_axi_wdata[7:0];
   assign flush = cmd_wr && cmd == `ITF_CMD_FIFO_FLUSH;
   assign all_suspend = acc_pmu_q == ITF_PMU_SUSPEND && gyr_pmu == ITF_PMU_SUSPEND && mag_suspend;
   assign legal = conf_legal(accel_rate_filter_config_q);
   assign accel_rate_filter_config_error = !legal;
   assign acc_undersample_en = accel_rate_filter_config_q[`ITF_CONF_US_BIT];
   assign acc_filter_coeff = accel_rate_filter_config_q[6:4];
   // the port index is decoded on every beat, so each repeated read of a non-empty fifo moves on one byte
   assign fifo_pop = rd_fire && rd_ok && rd_idx == `ITF_IDX_PORT;
   // any other register read ends a readout; a half-read frame is rewound
   assign fifo_abort = rd_fire && !(rd_ok && rd_idx == `ITF_IDX_PORT);
   assign acc_rd = rd_fire && rd_ok && (rd_idx == `ITF_IDX_ACC_X || rd_idx == `ITF_IDX_ACC_Y
      || rd_idx == `ITF_IDX_ACC_Z);

   itf_temp #(
      .FAST_CYC    (TEMP_FAST_CYC),
      .SLOW_CYC    (TEMP_SLOW_CYC)
   ) u_temp (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .all_suspend (all_suspend),
      .gyr_pmu     (gyr_pmu),
      .sample      (temp_sample),
      .word_q      (temp_word),
      .valid       (temp_valid)
   );

   itf_fifo #(
      .DEPTH    (FIFO_DEPTH),
      .FB       (`ITF_FRAME_BYTES)
   ) u_fifo (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .flush    (flush),
      .hdr_mode (fifo_hdr_q),
      .wr_valid (fifo_wr_valid),
      .wr_frame (fifo_wr_frame),
      .pop      (fifo_pop),
      .abort    (fifo_abort),
      .rd_byte  (fifo_byte),
      .level    (fifo_level)
   );

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= idx_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         accel_rate_filter_config_q  <= `ITF_ACCEL_RATE_FILTER_CONFIG_RST;
         acc_range_q <= `ITF_ACC_RANGE_RST;
         fifo_hdr_q  <= `ITF_FIFO_HDR_RST;
      end
      else if (wr_ok)
      begin
         if (wr_idx == `ITF_IDX_ACCEL_RATE_FILTER_CONFIG)
            accel_rate_filter_config_q <= s_axi_wdata[7:0];
         if (wr_idx == `ITF_IDX_ACC_RANGE)
            acc_range_q <= s_axi_wdata[3:0];
         if (wr_idx == `ITF_IDX_FIFO_CFG)
            fifo_hdr_q <= s_axi_wdata[`ITF_CFG_HDR_BIT];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         acc_range_sel_q <= ITF_RANGE_2G;
      else
         acc_range_sel_q <= range_decode(acc_range_q);
   end

   // accelerometer power state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         acc_pmu_q <= ITF_PMU_SUSPEND;
      else if (cmd_wr && cmd == `ITF_CMD_ACC_SUSPEND)
         acc_pmu_q <= ITF_PMU_SUSPEND;
      else if (cmd_wr && cmd == `ITF_CMD_ACC_NORMAL)
         acc_pmu_q <= ITF_PMU_NORMAL;
      else if (cmd_wr && cmd == `ITF_CMD_ACC_LOW_POWER && accel_rate_filter_config_q[`ITF_CONF_US_BIT])
         acc_pmu_q <= ITF_PMU_LOW_POWER;
      else if (acc_pmu_q == ITF_PMU_LOW_POWER && !accel_rate_filter_config_q[`ITF_CONF_US_BIT])
         acc_pmu_q <= ITF_PMU_NORMAL;
   end

   // output data rate divider
   assign odr_period = ODR_SLOW_CYC >> accel_rate_filter_config_q[3:0];
   always_ff @(posedge aclk)
   begin
      if (!aresetn || acc_pmu_q == ITF_PMU_SUSPEND || !legal)
      begin
         odr_cnt_q      <= 32'd0;
         acc_odr_tick_q <= 1'b0;
      end
      else if (odr_cnt_q >= odr_period - 32'd1)
      begin
         odr_cnt_q      <= 32'd0;
         acc_odr_tick_q <= 1'b1;
      end
      else
      begin
         odr_cnt_q      <= odr_cnt_q + 32'd1;
         acc_odr_tick_q <= 1'b0;
      end
   end

   // accelerometer data and data-ready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         acc_data_q <= '0;
      else if (acc_sample_valid)
         acc_data_q <= acc_sample;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         drdy_q <= 1'b0;
      else if (acc_sample_valid)
         drdy_q <= 1'b1;
      else if (acc_rd)
         drdy_q <= 1'b0;
   end

   // read data path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_ok ? RESP_OKAY : RESP_DECERR;
         rdata_q  <= 32'h0000_0000;
         if (rd_ok)
            unique case (rd_idx)
               `ITF_IDX_ERR:
                  rdata_q[`ITF_ERR_LSB +: 4] <= legal ? 4'h0 : `ITF_ERR_ACCEL_RATE_FILTER_CONFIG;
               `ITF_IDX_PMU:
               begin
                  rdata_q[`ITF_PMU_ACC_LSB +: 2] <= acc_pmu_q;
                  rdata_q[`ITF_PMU_GYR_LSB +: 2] <= gyr_pmu;
               end
               `ITF_IDX_ACC_X:
                  rdata_q[15:0] <= acc_data_q.x;
               `ITF_IDX_ACC_Y:
                  rdata_q[15:0] <= acc_data_q.y;
               `ITF_IDX_ACC_Z:
                  rdata_q[15:0] <= acc_data_q.z;
               `ITF_IDX_STATUS:
               begin
                  rdata_q[`ITF_STAT_DRDY_BIT]   <= drdy_q;
                  rdata_q[`ITF_STAT_TVALID_BIT] <= temp_valid;
               end
               `ITF_IDX_TEMP:
                  rdata_q[15:0] <= temp_word;
               `ITF_IDX_LEVEL:
                  rdata_q[15:0] <= fifo_level;
               `ITF_IDX_PORT:
                  rdata_q[7:0] <= fifo_byte;
               `ITF_IDX_ACCEL_RATE_FILTER_CONFIG:
                  rdata_q[7:0] <= accel_rate_filter_config_q;
               `ITF_IDX_ACC_RANGE:
                  rdata_q[3:0] <= acc_range_q;
               `ITF_IDX_FIFO_CFG:
                  rdata_q[`ITF_CFG_HDR_BIT] <= fifo_hdr_q;
               default:
                  rdata_q <= 32'h0000_0000;
            endcase
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end
endmodule
`default_nettype wire

/* File: tb/itf_regs_checker.sv */
/*
 port assertions for the register bank.
 assumes one aclk domain with synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module itf_regs_checker
   import itf_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // accelerometer control
   input wire itf_pmu_t    acc_pmu_q,
   input wire logic        acc_undersample_en,
   input wire logic [2:0]  acc_filter_coeff,
   input wire logic        acc_odr_tick_q,
   input wire logic        accel_rate_filter_config_error
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wr_take_gate_a: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
      else $error("write taken while blocked");
   wr_answer_a: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   filt_illegal_a: assert property (!acc_undersample_en && acc_filter_coeff > 3'h2 |-> accel_rate_filter_config_error)
      else $error("illegal filter not flagged");
   lp_entry_gate_a: assert property ($changed(acc_pmu_q) && acc_pmu_q == ITF_PMU_LOW_POWER |-> acc_undersample_en)
      else $error("low power entered without undersampling");
   us_clear_wake_a: assert property (acc_pmu_q == ITF_PMU_LOW_POWER && !acc_undersample_en |=> acc_pmu_q == ITF_PMU_NORMAL)
      else $error("low power kept without undersampling");
   tick_idle_a: assert property ((accel_rate_filter_config_error || acc_pmu_q == ITF_PMU_SUSPEND) [*2] |-> !acc_odr_tick_q)
      else $error("rate tick while idle");
   cover property (acc_pmu_q == ITF_PMU_LOW_POWER);
   cover property (acc_odr_tick_q);
   cover property (accel_rate_filter_config_error);
endmodule
bind itf_regs itf_regs_checker chk (.*);
`default_nettype wire

/* File: tb/itf_host.sv */
/*
 axi4-lite host model, one write and one read at a time.
 assumes a free-running aclk; a wait that runs out raises hung.
*/
`timescale 1ns/1ps
`default_nettype none
module itf_host
#(
   parameter int AW = 12
)
(
   // clock
   input  wire logic          aclk,
   // write channels
   output logic [AW-1:0]      s_axi_awaddr,
   output logic               s_axi_awvalid,
   input  wire logic          s_axi_awready,
   output logic [31:0]        s_axi_wdata,
   output logic [3:0]         s_axi_wstrb,
   output logic               s_axi_wvalid,
   input  wire logic          s_axi_wready,
   input  wire logic [1:0]    s_axi_bresp,
   input  wire logic          s_axi_bvalid,
   output logic               s_axi_bready,
   // read channels
   output logic [AW-1:0]      s_axi_araddr,
   output logic               s_axi_arvalid,
   input  wire logic          s_axi_arready,
   input  wire logic [31:0]   s_axi_rdata,
   input  wire logic [1:0]    s_axi_rresp,
   input  wire logic          s_axi_rvalid,
   output logic               s_axi_rready,
   // status
   output logic               hung
);
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
   end
   task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= AW'({idx, 2'b00});
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready) && ++n < 99);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid && ++n < 99);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 99)
         hung <= 1'b1;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= AW'({idx, 2'b00});
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do @(posedge aclk); while (!s_axi_arready && ++n < 99);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid && ++n < 99);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 99)
         hung <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
 register bank bench: host model on the bus, sensor and fifo inputs driven here.
 assumes shortened timing parameters on the bank.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("ERROR %0t: got %0h exp %0h", $time, a, e); end end
module testbench
   import itf_pkg::*;
   ;
   logic            aclk = 1'b0;
   logic            aresetn = 1'b0;
   logic [11:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]     s_axi_wdata, s_axi_rdata, d;
   logic [3:0]      s_axi_wstrb;
   logic [1:0]      s_axi_bresp, s_axi_rresp, r;
   logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
   logic            acc_sample_valid = 1'b0, mag_suspend = 1'b0, fifo_wr_valid = 1'b0;
   itf_acc_sample_t acc_sample = 48'hA5A5_0000_0000;
   itf_pmu_t        gyr_pmu = ITF_PMU_NORMAL, acc_pmu_q;
   logic [15:0]     temp_sample = 16'h1234;
   itf_frame_t      fifo_wr_frame = {8'h84, 48'h1111_2222_3333};
   itf_range_t      acc_range_sel_q;
   logic            acc_undersample_en, acc_odr_tick_q, accel_rate_filter_config_error;
   logic [2:0]      acc_filter_coeff;
   logic [7:0]      fb [7] = '{8'h84, 8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33};
   logic [3:0]      rc [6] = '{4'h3, 4'h5, 4'h8, 4'hC, 4'h0, 4'h7};
   itf_range_t      rs [6] = '{ITF_RANGE_2G, ITF_RANGE_4G, ITF_RANGE_8G, ITF_RANGE_16G, ITF_RANGE_2G, ITF_RANGE_2G};
   logic [7:0]      cf [7] = '{8'h28, 8'h38, 8'h20, 8'h2D, 8'h24, 8'hB8, 8'h2C};
   logic            ce [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   int              mismatches = 0, checks_done = 0, n;

   itf_host host (.*);
   itf_regs #(.TEMP_FAST_CYC(20), .TEMP_SLOW_CYC(50), .ODR_SLOW_CYC(4096), .FIFO_DEPTH(64)) dut (.*);

   always #5 aclk = ~aclk;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
      host.rd(idx, d, r);
      `CHK(d, e)
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] v);
      host.wr(idx, v, r);
      @(negedge aclk);
      `CHK(r, 2'b00)
   endtask
   task automatic period(input int e);
      repeat (2)
      begin
         n = 0;
         do @(posedge aclk); while (!acc_odr_tick_q && ++n < 5000);
      end
      `CHK(n + 1, e)
   endtask

   always @(posedge aclk)
      if (hung)
      begin
         mismatches++;
         wrap_up();
      end

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(8'h40, 32'h28);
      rchk(8'h41, 32'h3);
      rchk(8'h20, 32'h8000);
      rchk(8'h22, 32'h0);
      host.rd(8'hFF, d, r);
      `CHK(r, 2'b11)
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         wr(8'h41, {28'h0, rc[i]});
         `CHK(acc_range_sel_q, rs[i])
      end
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h40, {24'h0, cf[i]});
         `CHK(accel_rate_filter_config_error, ce[i])
         `CHK({acc_undersample_en, acc_filter_coeff}, cf[i][7:4])
         rchk(8'h02, ce[i] ? 32'hC : 32'h0);
      end
      wr(8'h7E, 32'h11);
      wr(8'h40, 32'h28);
      period(16);
      wr(8'h40, 32'h29);
      period(8);
      wr(8'h40, 32'h28);
      wr(8'h7E, 32'h12);
      `CHK(acc_pmu_q, ITF_PMU_NORMAL)
      wr(8'h40, 32'h88);
      wr(8'h7E, 32'h12);
      `CHK(acc_pmu_q, ITF_PMU_LOW_POWER)
      wr(8'h40, 32'h08);
      repeat (2) @(posedge aclk);
      `CHK(acc_pmu_q, ITF_PMU_NORMAL)
      $display("test accel config done");
      acc_sample_valid <= 1'b1;
      @(posedge aclk);
      acc_sample_valid <= 1'b0;
      host.rd(8'h1B, d, r);
      `CHK(d[7], 1'b1)
      wr(8'h41, 32'h8);
      host.rd(8'h1B, d, r);
      `CHK(d[7], 1'b1)
      rchk(8'h12, 32'hA5A5);
      host.rd(8'h1B, d, r);
      `CHK(d[7], 1'b0)
      $display("test data ready done");
      rchk(8'h20, 32'h1234);
      temp_sample <= 16'h0F0F;
      repeat (22) @(posedge aclk);
      rchk(8'h20, 32'h0F0F);
      host.rd(8'h1B, d, r);
      `CHK(d[0], 1'b1)
      gyr_pmu <= ITF_PMU_SUSPEND;
      temp_sample <= 16'h0707;
      repeat (52) @(posedge aclk);
      rchk(8'h20, 32'h0707);
      host.rd(8'h1B, d, r);
      `CHK(d[0], 1'b0)
      mag_suspend <= 1'b1;
      wr(8'h7E, 32'h10);
      repeat (2) @(posedge aclk);
      rchk(8'h20, 32'h8000);
      $display("test temperature done");
      fifo_wr_valid <= 1'b1;
      repeat (2) @(posedge aclk);
      fifo_wr_valid <= 1'b0;
      rchk(8'h22, 32'hE);
      for (int i = 0; i < 3; i++)
         rchk(8'h24, {24'h0, fb[i]});
      rchk(8'h22, 32'hE);
      for (int i = 0; i < 7; i++)
         rchk(8'h24, {24'h0, fb[i]});
      rchk(8'h22, 32'h7);
      wr(8'h47, 32'h0);
      for (int i = 1; i < 7; i++)
         rchk(8'h24, {24'h0, fb[i]});
      rchk(8'h22, 32'h0);
      fifo_wr_valid <= 1'b1;
      @(posedge aclk);
      fifo_wr_valid <= 1'b0;
      wr(8'h7E, 32'hB0);
      rchk(8'h22, 32'h0);
      $display("test fifo done");
      wrap_up();
   end
endmodule
`default_nettype wire
